// [pkg/pmam_map.svh]
// Register offsets, field positions, reset values and timing constants.
`ifndef PMAM_MAP_SVH
`define PMAM_MAP_SVH

// Clock and timebase.
`define PM_CLK_NS       10
`define PM_TB_NS        1000
`define PM_TB_CYC       (`PM_TB_NS / `PM_CLK_NS)
`define PM_SETTLE_US    300

// Conversion period limits and default, in timebase ticks of one microsecond, and the averaging exponent limit.
`define PM_PER_MIN_US   13'h0032
`define PM_PER_MAX_US   13'h1018
`define PM_PER_RST      13'h041C
`define PM_AVG_MAX      4'hA

// Register indices on the word port.
`define PM_REG_CTRL     4'h0
`define PM_REG_CFG      4'h1
`define PM_REG_PER_SH   4'h2
`define PM_REG_PER_BUS  4'h3
`define PM_REG_PER_TMP  4'h4
`define PM_REG_DIAG     4'h5
`define PM_REG_THR0     4'h6
`define PM_REG_RES0     4'hC

// Field positions.
`define PM_CTRL_RST     0
`define PM_CFG_MODE     1:0
`define PM_CFG_CHEN     6:4
`define PM_CFG_AVG      11:8
`define PM_DG_CTL       15:12
`define PM_CTL_HOLD     3
`define PM_CTL_DPIN     2
`define PM_CTL_AVGC     1
`define PM_CTL_INV      0

// Mode encodings and reset values.
`define PM_MODE_OFF     2'h0
`define PM_MODE_TRIG    2'h1
`define PM_MODE_RST     2'h2
`define PM_CHEN_RST     3'h7
`define PM_THR_SLOW_RST 16'h8000
`define PM_THR_SHI_RST  16'h7FFF
`define PM_THR_BHI_RST  16'h7FFF
`define PM_THR_BLO_RST  16'h0000
`define PM_THR_HEAT_RST 16'hFFFF
`define PM_THR_WATT_RST 16'h7FFF

`endif

// [pkg/pmam_pkg.sv]
// Types shared by the power monitor alert and mode logic.
package pmam_pkg;

	typedef enum logic [2:0] {
		PMAM_SETTLE,
		PMAM_IDLE,
		PMAM_START,
		PMAM_CONV,
		PMAM_SEQEND
	} pmam_state_e;

	typedef struct packed {
		pmam_state_e       st;
		logic [1:0]        mode;
		logic [2:0]        chan_en;
		logic [3:0]        avg_exp;
		logic [2:0][12:0]  per;
		logic [3:0]        dctl;
		logic [5:0]        flags;
		logic              done;
		logic              ovf;
		logic              trim_m;
		logic              trim_s;
		logic [5:0][15:0]  thr;
		logic [3:0][15:0]  res;
		logic [2:0][15:0]  samp;
		logic [2:0][26:0]  acc;
		logic [10:0]       nsmp;
		logic [1:0]        ch;
		logic [6:0]        tdiv;
		logic              tick;
		logic [12:0]       pcnt;
		logic [15:0]       scnt;
		logic              got;
		logic [15:0]       cap;
		logic              hold_alert;
		logic [15:0]       rdata;
		logic              rvalid;
		logic              cstart;
		logic [1:0]        cch;
		logic [12:0]       flen;
		logic              alert_oe;
		logic              alert_o;
		logic              ready;
	} pmam_st_s;

endpackage : pmam_pkg

// [verilog/pmam_top.sv]
// Conversion sequencing, threshold diagnostics and alert pin of the monitor.
`timescale 1ns/1ns
`include "pmam_map.svh"

// Functional notes
// R1: Filter settles inside one conversion period.
// R2: Filter null tracks half the output rate.
// R3: Per-channel periods, 50 us to 4.12 ms.
// R4: Averaging 1 to 1024, same for all channels.
// R5: Wait 300 us after power-up before converting.
// R6: Compare results to thresholds, set status flags.
// R7: Shunt and power thresholds signed, given resets.
// R8: Bus and heat thresholds positive, given resets.
// R9: Host reads status to find alert cause.
// R10: Latch mode holds alert after conditions clear.
// R11: Status read releases latched alert.
// R12: Completion sets flag; pin only when enabled.
// R13: Averaged compare uses averaged results.
// R14: Alert active low by default; invert bit.
// R15: Overflow flag set, never drives alert.
// R16: Trim health flag reads one when healthy.
// R17: Registers stay accessible in shutdown.
// R18: Shutdown holds until trigger or continuous written.
// R19: Trigger runs one sequence, then shutdown.
// R20: Power-on reset loads all defaults.
// R21: Reset bit performs full register reset.
// R22: Config write or status read clears completion; code clears on config write only if mode is not shutdown.
// R23: Mode write aborts and restarts the sequence.
// R24: Alert from flags or enabled completion, then polarity.
module pmam_top #(
	parameter int SETTLE_US = `PM_SETTLE_US
) (
	input  logic        REF_CLK,
	input  logic        RST_N,
	input  logic        REG_WR,
	input  logic        REG_RD,
	input  logic [3:0]  REG_ADDR,
	input  logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	output logic        REG_RVALID,
	output logic        CONV_START,
	output logic [1:0]  CONV_CH,
	output logic [12:0] FILT_LEN,
	input  logic        RES_VALID,
	input  logic [15:0] RES_DATA,
	input  logic        TRIM_OK,
	output logic        ALERT_O,
	output logic        ALERT_OE,
	output logic        SETTLED
);

	// ****************************************************************
	// Constants and state
	// ****************************************************************

	localparam logic [6:0]  TB_LAST     = 7'(`PM_TB_CYC - 1);
	localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_US - 1);

	// Every register takes its default on reset. [R20] [R7] [R8]
	localparam pmam_pkg::pmam_st_s RST = '{
		st:      pmam_pkg::PMAM_SETTLE,
		mode:    `PM_MODE_RST,
		chan_en: `PM_CHEN_RST,
		per:     {3{`PM_PER_RST}},
		thr:     {`PM_THR_WATT_RST, `PM_THR_HEAT_RST, `PM_THR_BLO_RST,
		          `PM_THR_BHI_RST, `PM_THR_SHI_RST, `PM_THR_SLOW_RST},
		default: '0
	};

	pmam_pkg::pmam_st_s q;
	pmam_pkg::pmam_st_s n;
	logic [15:0][15:0]  view;
	logic               pub;
	logic               act;
	logic               pin_act;
	logic               wr_cfg;
	logic               rd_diag;
	logic               soft_rst;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Power from shunt magnitude and bus; bit 16 flags an overflow.
	function automatic logic [16:0] pw_calc(input logic [15:0] sh,
	                                        input logic [15:0] bus);
		logic [15:0] mag;
		logic [31:0] p;
		mag = sh[15] ? 16'(-sh) : sh;
		p = 32'(mag) * 32'(bus);
		if (p[31:30] != 2'h0) begin
			pw_calc = {1'b1, 16'h7FFF}; // Saturates on overflow. [R15]
		end else begin
			pw_calc = {1'b0, p[30:15]};
		end
	endfunction : pw_calc

	// Out-of-range checks; shunt and power are signed. [R7]
	// Bus and heat compare as positive magnitudes only. [R8]
	function automatic logic [5:0] cmp(input logic [3:0][15:0] v,
	                                   input logic [5:0][15:0] t);
		cmp[0] = $signed(v[0]) < $signed(t[0]);
		cmp[1] = $signed(v[0]) > $signed(t[1]);
		cmp[2] = v[1] > t[2];
		cmp[3] = v[1] < t[3];
		cmp[4] = !v[2][15] && (v[2] > t[4]);
		cmp[5] = $signed(v[3]) > $signed(t[5]);
	endfunction : cmp

	// Clamps a written period into the supported range. [R3]
	function automatic logic [12:0] clamp_per(input logic [15:0] w);
		if (w < 16'(`PM_PER_MIN_US)) begin
			clamp_per = `PM_PER_MIN_US;
		end else if (w > 16'(`PM_PER_MAX_US)) begin
			clamp_per = `PM_PER_MAX_US;
		end else begin
			clamp_per = w[12:0];
		end
	endfunction : clamp_per

	// ****************************************************************
	// Register port decode and read view
	// ****************************************************************

	// Decoded accesses with side effects.
	assign wr_cfg   = REG_WR && (REG_ADDR == `PM_REG_CFG);
	assign rd_diag  = REG_RD && (REG_ADDR == `PM_REG_DIAG);
	assign soft_rst = REG_WR && (REG_ADDR == `PM_REG_CTRL) &&
	                  REG_WDATA[`PM_CTRL_RST];

	// Readable image of every register; control word reads zero.
	always_comb begin
		view = '0;
		view[`PM_REG_CFG] = {4'h0, q.avg_exp, 1'b0, q.chan_en, 2'h0, q.mode};
		view[`PM_REG_PER_SH]  = {3'h0, q.per[0]};
		view[`PM_REG_PER_BUS] = {3'h0, q.per[1]};
		view[`PM_REG_PER_TMP] = {3'h0, q.per[2]};
		// Status: flags, completion, overflow, trim health. [R9] [R16]
		view[`PM_REG_DIAG] = {q.dctl, 2'h0, q.ovf, 1'b0, q.flags, q.done,
		                      q.trim_s};
		for (int i = 0; i < 6; i++) begin
			view[4'(`PM_REG_THR0 + i)] = q.thr[i];
		end
		for (int i = 0; i < 4; i++) begin
			view[4'(`PM_REG_RES0 + i)] = q.res[i];
		end
	end

	// Alert sources; overflow is deliberately not among them. [R24] [R15]
	assign act     = (|q.flags) | (q.dctl[`PM_CTL_DPIN] & q.done);
	assign pin_act = act | q.hold_alert;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************

	// Completion, overflow and flag clears are applied first so that a same-cycle set wins.
	always_comb begin
		logic [5:0]       c;
		logic [16:0]      p;
		logic [15:0]      s;
		logic [2:0][15:0] av;
		logic [3:0][15:0] v;
		logic             last;
		logic             evt;
		c = '0;
		p = '0;
		s = '0;
		av = '0;
		v = '0;
		last = 1'b0;
		evt = 1'b0;
		pub = 1'b0;
		n = q;
		n.cstart = 1'b0;
		n.rvalid = REG_RD;
		n.rdata = view[REG_ADDR];
		n.trim_m = TRIM_OK;
		n.trim_s = q.trim_m;
		n.tick = (q.tdiv == TB_LAST);
		n.tdiv = n.tick ? 7'h00 : q.tdiv + 7'h01;

		// Status read clears completion, overflow, held flags. [R22]
		if (rd_diag) begin
			n.done = 1'b0;
			n.ovf = 1'b0;
			if (q.dctl[`PM_CTL_HOLD]) begin
				n.flags = '0;
			end
		end

		// Writes are taken in every state, shutdown included. [R17]
		if (REG_WR) begin
			case (REG_ADDR)
				`PM_REG_CFG: begin
					n.mode = REG_WDATA[`PM_CFG_MODE];
					n.chan_en = REG_WDATA[`PM_CFG_CHEN];
					n.avg_exp = (REG_WDATA[`PM_CFG_AVG] > `PM_AVG_MAX) ?
					            `PM_AVG_MAX : REG_WDATA[`PM_CFG_AVG]; // [R4]
					if (REG_WDATA[`PM_CFG_MODE] != `PM_MODE_OFF) begin
						n.done = 1'b0; // [R22]
					end
				end
				`PM_REG_PER_SH:  n.per[0] = clamp_per(REG_WDATA); // [R3]
				`PM_REG_PER_BUS: n.per[1] = clamp_per(REG_WDATA); // [R3]
				`PM_REG_PER_TMP: n.per[2] = clamp_per(REG_WDATA); // [R3]
				`PM_REG_DIAG:    n.dctl = REG_WDATA[`PM_DG_CTL];
				default: begin
					for (int i = 0; i < 6; i++) begin
						if (REG_ADDR == 4'(`PM_REG_THR0 + i)) begin
							n.thr[i] = REG_WDATA;
						end
					end
				end
			endcase
		end

		// Conversion sequencer.
		case (q.st)
			pmam_pkg::PMAM_SETTLE: begin
				if (q.tick) begin
					n.scnt = q.scnt + 16'h0001;
					if (q.scnt == SETTLE_LAST) begin
						n.ready = 1'b1; // [R5]
						n.st = (q.mode != `PM_MODE_OFF) ?
						       pmam_pkg::PMAM_START : pmam_pkg::PMAM_IDLE;
					end
				end
			end
			pmam_pkg::PMAM_IDLE: begin
				// Shutdown leaves only on a continuous mode here. [R18]
				if (q.mode[1]) begin
					n.st = pmam_pkg::PMAM_START;
					n.ch = 2'h0;
				end
			end
			pmam_pkg::PMAM_START: begin
				if (q.chan_en[q.ch]) begin
					n.cstart = 1'b1;
					n.cch = q.ch;
					n.flen = q.per[q.ch]; // Filter length per period. [R1] [R2]
					n.pcnt = '0;
					n.got = 1'b0;
					n.st = pmam_pkg::PMAM_CONV;
				end else if (q.ch == 2'h2) begin
					n.st = pmam_pkg::PMAM_SEQEND;
				end else begin
					n.ch = q.ch + 2'h1;
				end
			end
			pmam_pkg::PMAM_CONV: begin
				if (RES_VALID) begin
					n.got = 1'b1;
					n.cap = RES_DATA;
				end
				if (q.tick) begin
					n.pcnt = q.pcnt + 13'h0001;
					// The result is taken when the period runs out. [R1]
					if (q.pcnt + 13'h0001 >= q.per[q.ch]) begin
						s = RES_VALID ? RES_DATA :
						    (q.got ? q.cap : q.samp[q.ch]);
						n.samp[q.ch] = s;
						n.acc[q.ch] = q.acc[q.ch] + {{11{s[15]}}, s};
						p = pw_calc(n.samp[0], n.samp[1]);
						v = {p[15:0], n.samp};
						evt = !q.dctl[`PM_CTL_AVGC]; // [R13]
						n.st = (q.ch == 2'h2) ? pmam_pkg::PMAM_SEQEND :
						       pmam_pkg::PMAM_START;
						n.ch = q.ch + 2'h1;
					end
				end
			end
			pmam_pkg::PMAM_SEQEND: begin
				last = (q.nsmp == (11'h001 << q.avg_exp) - 11'h001); // [R4]
				n.ch = 2'h0;
				n.nsmp = q.nsmp + 11'h001;
				n.st = pmam_pkg::PMAM_START;
				if (last) begin
					pub = 1'b1;
					for (int i = 0; i < 3; i++) begin
						av[i] = 16'($signed(q.acc[i]) >>> q.avg_exp); // [R4]
					end
					p = pw_calc(av[0], av[1]);
					n.res = {p[15:0], av};
					v = n.res;
					evt = q.dctl[`PM_CTL_AVGC]; // [R13]
					n.acc = '0;
					n.nsmp = '0;
					n.done = 1'b1; // Set whatever the pin enable. [R12]
					if (q.mode == `PM_MODE_TRIG) begin
						n.st = pmam_pkg::PMAM_IDLE; // [R19]
					end
				end
			end
			default: n.st = pmam_pkg::PMAM_IDLE;
		endcase

		// Overflow and threshold flags. [R15] [R6] [R10]
		if (p[16]) begin
			n.ovf = 1'b1;
		end
		if (evt) begin
			c = cmp(v, q.thr);
			n.flags = q.dctl[`PM_CTL_HOLD] ? (n.flags | c) : c;
		end

		// A config write after settling aborts the sequence; it restarts unless shutdown is written. [R23]
		if (wr_cfg && q.st != pmam_pkg::PMAM_SETTLE) begin
			n.st = (n.mode != `PM_MODE_OFF) ? pmam_pkg::PMAM_START :
			       pmam_pkg::PMAM_IDLE;
			n.acc = '0;
			n.nsmp = '0;
			n.ch = 2'h0;
		end

		// Held until a status read; the read wins. [R10] [R11]
		n.hold_alert = rd_diag ? 1'b0 :
		               (q.hold_alert | (q.dctl[`PM_CTL_HOLD] & act));
		// Open drain: drive low when the pin must read low. [R14] [R24]
		n.alert_oe = q.dctl[`PM_CTL_INV] ? !pin_act : pin_act;
		n.alert_o = 1'b0;

		// Software reset: all registers back to defaults. [R21]
		if (soft_rst) begin
			n = RST;
			n.st = q.ready ? pmam_pkg::PMAM_IDLE : q.st;
			n.scnt = q.scnt;
			n.ready = q.ready;
			n.tdiv = q.tdiv;
			n.trim_m = q.trim_m;
			n.trim_s = q.trim_s;
		end
	end

	// ****************************************************************
	// State register and outputs
	// ****************************************************************

	// All state in one register. [R20]
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			q <= RST;
		end else begin
			q <= n;
		end
	end

	// Outputs straight from the state register.
	assign REG_RDATA  = q.rdata;
	assign REG_RVALID = q.rvalid;
	assign CONV_START = q.cstart;
	assign CONV_CH    = q.cch;
	assign FILT_LEN   = q.flen;
	assign ALERT_O    = q.alert_o;
	assign ALERT_OE   = q.alert_oe;
	assign SETTLED    = q.ready;

	// ****************************************************************
	// Assertions
	// ****************************************************************

	default clocking pm_cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	// A triggered sequence ends in shutdown with no new conversion.
	sequence pm_trig_done;
		pub && q.mode == `PM_MODE_TRIG && !wr_cfg && !soft_rst;
	endsequence
	sequence pm_stay_off;
		q.st == pmam_pkg::PMAM_IDLE ##1 !q.cstart;
	endsequence

	done_set_a: assert property (pub && !soft_rst |=> q.done) // [R12]
		else $error("Completion flag not set after publish.");
	done_clear_a: assert property (rd_diag && !pub |=> !q.done) // [R22]
		else $error("Completion flag survived status read.");
	period_range_a: assert property ( // [R3]
		q.per[0] >= `PM_PER_MIN_US && q.per[0] <= `PM_PER_MAX_US &&
		q.per[1] >= `PM_PER_MIN_US && q.per[1] <= `PM_PER_MAX_US &&
		q.per[2] >= `PM_PER_MIN_US && q.per[2] <= `PM_PER_MAX_US)
		else $error("Conversion period out of range.");
	polarity_low_a: assert property ( // [R14]
		pin_act && !q.dctl[`PM_CTL_INV] && !soft_rst |=> q.alert_oe)
		else $error("Active low alert not driven.");
	hold_keep_a: assert property ( // [R10]
		q.dctl[`PM_CTL_HOLD] && q.hold_alert && !rd_diag && !soft_rst
		|=> q.hold_alert)
		else $error("Latched alert dropped without a read.");
	read_release_a: assert property ( // [R11]
		rd_diag && !soft_rst |=> !q.hold_alert)
		else $error("Status read did not release alert.");
	trig_off_a: assert property (pm_trig_done |=> pm_stay_off) // [R19]
		else $error("Triggered run did not return to shutdown.");
	restart_a: assert property ( // [R23]
		wr_cfg && REG_WDATA[`PM_CFG_MODE] != `PM_MODE_OFF &&
		q.st != pmam_pkg::PMAM_SETTLE
		|=> q.st == pmam_pkg::PMAM_START && q.nsmp == 11'h000)
		else $error("Mode write did not restart sequence.");
	settle_wait_a: assert property ( // [R5]
		q.st == pmam_pkg::PMAM_SETTLE |-> !q.cstart && !q.ready)
		else $error("Conversion started before settling.");
	soft_reset_a: assert property ( // [R21]
		soft_rst |=> q.thr == RST.thr && q.mode == `PM_MODE_RST &&
		q.dctl == 4'h0)
		else $error("Reset bit did not restore defaults.");

endmodule : pmam_top

// [verification/pmam_fe_model.sv]
// Behavioural front end that answers the latest conversion request of the block.
`timescale 1ns/1ns

module pmam_fe_model (
	input  logic             clk,
	input  logic             rst_n,
	input  logic             conv_start,
	input  logic [1:0]       conv_ch,
	input  logic [12:0]      filt_len,
	input  logic [2:0][15:0] fe_val,
	output logic             res_valid,
	output logic [15:0]      res_data
);
	logic        pend;
	logic        slow;
	logic [1:0]  ch;
	logic [15:0] last;
	int          cnt;

	// Answers alternate between prompt and late in the period; outside the
	// strobe the data lines carry the inverse of the last result.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend      <= 1'b0;
			slow      <= 1'b0;
			ch        <= 2'h0;
			last      <= 16'h0000;
			cnt       <= 0;
			res_valid <= 1'b0;
			res_data  <= 16'hFFFF;
		end else begin
			res_valid <= 1'b0;
			res_data  <= ~last;
			if (conv_start) begin
				pend <= 1'b1;
				ch   <= conv_ch;
				slow <= ~slow;
				cnt  <= slow ? int'(filt_len) * 80 : 3;
			end else if (pend && cnt == 0) begin
				pend      <= 1'b0;
				res_valid <= 1'b1;
				res_data  <= fe_val[ch];
				last      <= fe_val[ch];
			end else if (pend) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : pmam_fe_model

// [verification/tb.sv]
// Self-checking bench for the alert and conversion mode logic.
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
	logic             ref_clk;
	logic             rst_n;
	logic             reg_wr;
	logic             reg_rd;
	logic [3:0]       reg_addr;
	logic [15:0]      reg_wdata;
	logic [15:0]      reg_rdata;
	logic             reg_rvalid;
	logic             conv_start;
	logic [1:0]       conv_ch;
	logic [12:0]      filt_len;
	logic             res_valid;
	logic [15:0]      res_data;
	logic             trim_ok;
	logic             alert_o;
	logic             alert_oe;
	logic             settled;
	logic [2:0][15:0] fe_val;
	logic [15:0]      exp_q[$];
	logic [15:0]      e_v;
	logic [15:0]      r;
	int               failures;
	int               n_checks;
	int               n;
	logic [15:0]      dflt [12] = '{16'h0000, 16'h0072, 16'h041C,
		16'h041C, 16'h041C, 16'h0001, 16'h8000, 16'h7FFF, 16'h7FFF,
		16'h0000, 16'hFFFF, 16'h7FFF};

	pmam_top #(.SETTLE_US(2)) pmam_top_i (
		.REF_CLK    (ref_clk),
		.RST_N      (rst_n),
		.REG_WR     (reg_wr),
		.REG_RD     (reg_rd),
		.REG_ADDR   (reg_addr),
		.REG_WDATA  (reg_wdata),
		.REG_RDATA  (reg_rdata),
		.REG_RVALID (reg_rvalid),
		.CONV_START (conv_start),
		.CONV_CH    (conv_ch),
		.FILT_LEN   (filt_len),
		.RES_VALID  (res_valid),
		.RES_DATA   (res_data),
		.TRIM_OK    (trim_ok),
		.ALERT_O    (alert_o),
		.ALERT_OE   (alert_oe),
		.SETTLED    (settled)
	);

	pmam_fe_model pmam_fe_model_i (
		.clk        (ref_clk),
		.rst_n      (rst_n),
		.conv_start (conv_start),
		.conv_ch    (conv_ch),
		.filt_len   (filt_len),
		.fe_val     (fe_val),
		.res_valid  (res_valid),
		.res_data   (res_data)
	);

	// ****************************************************************
	// Clock, bus tasks and closing report
	// ****************************************************************

	// Free-running 100 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic complete_run();
		$display("Checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	// One-cycle write strobe.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		reg_wr    = 1'b1;
		reg_addr  = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask : wr

	// One-cycle read strobe; the expected word waits in the queue.
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(negedge ref_clk);
		reg_rd   = 1'b1;
		reg_addr = a;
		exp_q.push_back(e);
		@(negedge ref_clk);
		reg_rd = 1'b0;
	endtask : rd

	// Waits a bounded time for a conversion request.
	task automatic wait_start(input int lim, output int c);
		c = 0;
		while (conv_start !== 1'b1 && c < lim) begin
			@(negedge ref_clk);
			c++;
		end
		if (conv_start !== 1'b1) begin
			failures++;
			complete_run();
		end
	endtask : wait_start

	// Counts conversion requests over a quiet stretch.
	task automatic no_start(input int cyc);
		n = 0;
		repeat (cyc) begin
			@(negedge ref_clk);
			if (conv_start === 1'b1) n++;
		end
		`CHK(n, 0)
	endtask : no_start

	// Triggered run of the shunt channel, waited out for one period.
	task automatic trig();
		wr(4'h1, 16'h0011);
		wait_start(20, n);
		`CHK(filt_len, 13'h0032)
		`CHK(conv_ch, 2'h0)
		repeat (5150) @(negedge ref_clk);
	endtask : trig

	// Reads register indices 0 to 11 against their reset values.
	task automatic defaults();
		for (int i = 0; i < 12; i++) begin
			rd(i[3:0], dflt[i]);
		end
	endtask : defaults

	// Takes the oldest expected word whenever a read answer appears.
	always @(negedge ref_clk) begin
		if (reg_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				`CHK(reg_rvalid, 1'b0)
			end else begin
				e_v = exp_q.pop_front();
				`CHK(reg_rdata, e_v)
			end
		end
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************

	// Startup, register checks, triggered runs, alert modes and abort.
	initial begin
		rst_n     = 1'b0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 4'h0;
		reg_wdata = 16'h0000;
		trim_ok   = 1'b1;
		fe_val    = '0;
		failures  = 0;
		n_checks  = 0;
		void'($urandom(32'h981B3756));
		repeat (5) @(negedge ref_clk);
		rst_n = 1'b1;
		`CHK(settled, 1'b0)
		`CHK(alert_oe, 1'b0)
		defaults();
		wait_start(400, n);
		`CHK(settled, 1'b1)
		`CHK(filt_len, 13'h041C)
		wr(4'h1, 16'h0F70);
		rd(4'h1, 16'h0A70);
		no_start(300);
		wr(4'h2, 16'h0001);
		rd(4'h2, 16'h0032);
		wr(4'h3, 16'hFFFF);
		rd(4'h3, 16'h1018);
		r = 16'h0032 + 16'($urandom % 4071);
		wr(4'h4, r);
		rd(4'h4, r);
		for (int i = 6; i < 12; i++) begin
			r = 16'($urandom);
			wr(i[3:0], r);
			rd(i[3:0], r);
		end
		wr(4'h0, 16'h0001);
		defaults();
		wr(4'h1, 16'h0010);
		wr(4'h2, 16'h0032);
		fe_val[0] = 16'h0101 + 16'($urandom % 32'h7E00);
		wr(4'h7, 16'h0100);
		trig();
		`CHK(alert_oe, 1'b1)
		`CHK(alert_o, 1'b0)
		rd(4'h5, 16'h000B);
		rd(4'h5, 16'h0009);
		no_start(5500);
		wr(4'h5, 16'h1000);
		repeat (3) @(negedge ref_clk);
		`CHK(alert_oe, 1'b0)
		wr(4'h5, 16'h8000);
		trig();
		fe_val[0] = 16'h0000;
		trig();
		`CHK(alert_oe, 1'b1)
		rd(4'h5, 16'h800B);
		repeat (3) @(negedge ref_clk);
		`CHK(alert_oe, 1'b0)
		wr(4'h5, 16'h4000);
		trig();
		`CHK(alert_oe, 1'b1)
		rd(4'h5, 16'h4003);
		repeat (3) @(negedge ref_clk);
		`CHK(alert_oe, 1'b0)
		wr(4'h1, 16'h0013);
		wait_start(20, n);
		repeat (100) @(negedge ref_clk);
		wr(4'h1, 16'h0013);
		wait_start(20, n);
		`CHK(filt_len, 13'h0032)
		wr(4'h1, 16'h0010);
		// Averaged compare over two samples: no alert after the first one.
		wr(4'h5, 16'h2000);
		fe_val[0] = 16'h0200;
		wr(4'h1, 16'h0111);
		wait_start(20, n);
		repeat (5150) @(negedge ref_clk);
		`CHK(alert_oe, 1'b0)
		repeat (5000) @(negedge ref_clk);
		`CHK(alert_oe, 1'b1)
		rd(4'hC, 16'h0200);
		rd(4'h5, 16'h200B);
		// A failing trim store must show in the health bit.
		trim_ok = 1'b0;
		repeat (3) @(negedge ref_clk);
		rd(4'h5, 16'h2008);
		repeat (5) @(negedge ref_clk);
		`CHK(exp_q.size(), 0)
		complete_run();
	end
endmodule : tb
